// *** rtl/aad_channel.sv ***
// aad_channel: aux data channel with forward queue, return payload and registers
// assumes a classic wishbone master and link logic that takes the pulses
//
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
`include "aad_defs.svh"
module aad_channel #(
  parameter int FIFO_DEPTH = `AAD_FIFO_DEPTH,
  parameter int SPF = `AAD_SAMPLES_PER_FRAME,
  parameter int LQ_WINDOW = `AAD_LQ_WINDOW
) (
  input wire logic clk,
  input wire logic nrst,
  input aad_pkg::aad_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] general_inputs,
  input wire logic [7:0] parallel_port,
  input wire logic sample_tick,
  input wire logic pkt_done,
  input wire logic pkt_ok,
  input wire logic src_valid,
  input wire logic [7:0] src_data,
  output logic src_ready,
  output logic fwd_valid,
  output logic [7:0] fwd_data,
  input wire logic mst_valid,
  input wire logic [7:0] mst_addr,
  input wire logic [15:0] mst_data,
  output logic mst_ready,
  output logic ret_valid,
  output aad_pkg::aad_ret_payload_t ret_payload
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam int QW = $clog2(LQ_WINDOW) + 1;

  // the saturation to 255 assumes a 256-packet history
  initial begin
    if (LQ_WINDOW != 256) begin
      $error("aad_channel: LQ_WINDOW must be 256");
    end
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [1:0] ctrl;
    logic [3:0] gin;
    logic [LQ_WINDOW-1:0] hist;
    logic [QW-1:0] good;
    logic fv;
    logic [7:0] fd;
    logic rv;
    aad_pkg::aad_ret_payload_t rp;
    logic m_pend;
    logic m_half;
    logic [7:0] m_addr;
    logic [15:0] m_data;
    logic [7:0] m_seq;
  } aad_ch_st_t;

  aad_ch_st_t st_reg, st_next;

  logic frame_start, slot_tick, frame_odd;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_in_data, fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic req, wr, fwd_en, ret_en, sw_push;
  logic [7:0] idx;

  // count of good packets clipped to the 8-bit register range
  function automatic logic [7:0] lq_sat(input logic [QW-1:0] g);
    lq_sat = (g > QW'(255)) ? 8'hFF : g[7:0];
  endfunction

  // read mux; reserved and unmapped bits read as zero
  function automatic logic [31:0] rd_mux(input logic [7:0] i, input aad_ch_st_t s, input logic [LW-1:0] lvl);
    rd_mux = 32'h0000_0000;
    unique case (i)
      `AAD_IDX_GIN: rd_mux = {28'h000_0000, s.gin};
      `AAD_IDX_LINK_QUALITY_COUNT: rd_mux = {24'h00_0000, lq_sat(s.good)};
      `AAD_IDX_CTRL: rd_mux = {30'h0000_0000, s.ctrl};
      `AAD_IDX_STAT: rd_mux = {16'h0000, 8'(lvl), 5'h00, frame_odd, s.m_half, s.m_pend};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // bus request decode; byte address bits 9:2 carry the register index
  assign req = wb_req.cyc && wb_req.stb && !st_reg.ack;
  assign wr = req && wb_req.we;
  assign idx = (wb_req.adr[11:10] == 2'b00) ? wb_req.adr[9:2] : 8'hFF;
  assign fwd_en = st_reg.ctrl[`AAD_CTRL_FWD_EN];
  assign ret_en = st_reg.ctrl[`AAD_CTRL_RET_EN];

  // the pin source wins a tie, software waits with ack held off
  assign sw_push = wr && idx == `AAD_IDX_FWD && wb_req.sel[0] && !src_valid;
  assign fifo_in_valid = src_valid || sw_push; // R7
  assign fifo_in_data = src_valid ? src_data : wb_req.dat[7:0]; // R7
  assign src_ready = fifo_in_ready;
  assign fifo_pop = slot_tick && fwd_en && fifo_out_valid; // R3 R15

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdat;
  assign fwd_valid = st_reg.fv;
  assign fwd_data = st_reg.fd;
  assign ret_valid = st_reg.rv;
  assign ret_payload = st_reg.rp;
  assign mst_ready = !st_reg.m_pend;

  aad_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  aad_frame_timer #(
    .SPF(SPF),
    .PPF(`AAD_PKTS_PER_FRAME)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .en(fwd_en || ret_en),
    .sample_tick(sample_tick),
    .frame_start(frame_start),
    .slot_tick(slot_tick),
    .frame_odd(frame_odd)
  );

  // next-state logic for the whole channel
  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.fv = 1'b0;
    st_next.rv = 1'b0;

    // general inputs are sampled every cycle; upper nibble stays zero
    st_next.gin = general_inputs; // R1 R2

    // register slave: one cycle to ack, forward writes wait for room
    if (req) begin
      if (sw_push && !fifo_in_ready) begin
        st_next.ack = 1'b0;
      end else if (wr && idx == `AAD_IDX_FWD && wb_req.sel[0] && src_valid) begin
        st_next.ack = 1'b0; // retried next cycle once the pin source is idle
      end else begin
        st_next.ack = 1'b1;
        st_next.rdat = wb_req.we ? st_reg.rdat : rd_mux(idx, st_reg, fifo_level); // R1
        if (wr && idx == `AAD_IDX_CTRL && wb_req.sel[0]) begin
          st_next.ctrl = wb_req.dat[1:0];
        end
      end
    end

    // sliding window of the last 256 packet outcomes
    if (pkt_done) begin
      st_next.hist = {st_reg.hist[LQ_WINDOW-2:0], pkt_ok}; // R14
      st_next.good = st_reg.good + QW'(pkt_ok) - QW'(st_reg.hist[LQ_WINDOW-1]); // R14
    end

    // one queued byte per forward packet slot
    if (fifo_pop) begin
      st_next.fv = 1'b1; // R6
      st_next.fd = fifo_out_data; // R15
    end

    // master request is held until both halves have gone out
    if (mst_valid && !st_reg.m_pend) begin
      st_next.m_pend = 1'b1;
      st_next.m_addr = mst_addr;
      st_next.m_data = mst_data;
    end

    // one acknowledge payload per frame; even and odd frames split the shares
    if (frame_start && ret_en) begin
      st_next.rv = 1'b1; // R8
      st_next.rp.b0 = lq_sat(st_reg.good); // R10
      if (!frame_odd) begin
        st_next.rp.b1 = parallel_port; // R11
        st_next.rp.b2 = st_reg.m_pend ? `AAD_SYNC_BYTE : `AAD_SPARE_BYTE; // R12
        st_next.rp.b3 = st_reg.m_pend ? st_reg.m_addr : `AAD_SPARE_BYTE; // R12
        st_next.rp.b4 = st_reg.m_pend ? st_reg.m_data[7:0] : `AAD_SPARE_BYTE; // R12
        st_next.m_half = st_reg.m_pend; // R9
      end else begin
        st_next.rp.b1 = st_reg.m_half ? st_reg.m_seq : `AAD_SPARE_BYTE; // R12
        st_next.rp.b2 = st_reg.m_half ? st_reg.m_data[15:8] : `AAD_SPARE_BYTE; // R12
        st_next.rp.b3 = `AAD_SPARE_BYTE; // R13
        st_next.rp.b4 = `AAD_SPARE_BYTE; // R13
        if (st_reg.m_half) begin
          st_next.m_pend = 1'b0;
          st_next.m_half = 1'b0;
          st_next.m_seq = st_reg.m_seq + 8'h01;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.ctrl <= `AAD_CTRL_RESET;
      st_reg.gin <= `AAD_GIN_RESET;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// *** rtl/aad_defs.svh ***
// aad_defs.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from rtl files of the aux data channel
//
// Function
// R1 - register at 0x07 resets 0x00, bits 3:0 show general inputs 3:0
// R2 - bits 7:4 of that register are reserved and read as fixed zero
// R3 - forward aux data is carried in its own channel within the audio packets
// R4 - data frames start once every 8*16 audio samples
// R5 - average rate is frame rate times packets times bytes times eight bits
// R6 - forward channel carries four one-byte packets per frame at 48, 44.1 or 32 kHz
// R7 - all forward sources share a single queue, so one busy source delays others
// R8 - return channel rides in one acknowledge packet per frame carrying five bytes
// R9 - return bandwidth is shared by link quality, parallel port and master traffic
// R10 - link quality takes 20% of return bandwidth and refreshes at that rate
// R11 - parallel port state reporting takes 10% of return bandwidth
// R12 - master traffic takes 50%: 20% payload, 30% sync and address overhead
// R13 - the remaining 20% of return bandwidth stays unused
// R14 - link quality counts good packets of the last 256, saturating at 255
// R15 - the forward queue sends bytes in arrival order, one per packet slot
`ifndef AAD_DEFS_SVH
`define AAD_DEFS_SVH

// register indices; byte address is four times the index
`define AAD_IDX_LINK_QUALITY_COUNT 8'h04
`define AAD_IDX_GIN 8'h07
`define AAD_IDX_CTRL 8'h08
`define AAD_IDX_STAT 8'h09
`define AAD_IDX_FWD 8'h0A

// reset values and field positions
`define AAD_GIN_RESET 4'h0
`define AAD_CTRL_RESET 2'h3
`define AAD_CTRL_FWD_EN 0
`define AAD_CTRL_RET_EN 1

// frame timing and payload shape
`define AAD_SAMPLES_PER_FRAME (8*16)
`define AAD_PKTS_PER_FRAME 4
`define AAD_RET_BYTES 5
`define AAD_LQ_WINDOW 256
`define AAD_FIFO_DEPTH 8
`define AAD_SYNC_BYTE 8'hA5
`define AAD_SPARE_BYTE 8'h00

`endif

// *** rtl/aad_fifo.sv ***
// aad_fifo: shared forward byte queue with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module aad_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  // pointer wrap relies on a power-of-two depth
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("aad_fifo: DEPTH must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } aad_fifo_st_t;

  aad_fifo_st_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = (st_reg.wp ^ st_reg.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = st_reg.wp != st_reg.rp;
  assign out_data = mem[st_reg.rp[AW-1:0]];
  assign level = st_reg.wp - st_reg.rp;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer update, strict arrival order
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + 1'b1; // R15
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1; // R15
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // storage holds no control state, so it needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

// *** rtl/aad_frame_timer.sv ***
// aad_frame_timer: derives frame starts and packet slots from audio samples
// assumes sample_tick is a one-cycle pulse per audio sample
`timescale 1ns/10ps
`include "aad_defs.svh"
module aad_frame_timer #(
  parameter int SPF = `AAD_SAMPLES_PER_FRAME,
  parameter int PPF = `AAD_PKTS_PER_FRAME
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic sample_tick,
  output logic frame_start,
  output logic slot_tick,
  output logic frame_odd
);
  localparam int CW = $clog2(SPF);
  localparam int SPP = SPF / PPF;
  localparam int SW = (SPP > 1) ? $clog2(SPP) : 1;

  // slot boundaries are taken from low counter bits
  initial begin
    if ((SPF & (SPF - 1)) != 0 || (SPP & (SPP - 1)) != 0 || SPP < 2 || SPF != SPP * PPF) begin
      $error("aad_frame_timer: SPF and SPF/PPF must be powers of two");
    end
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic odd;
    logic fs;
    logic sl;
    logic par;
  } aad_tmr_st_t;

  aad_tmr_st_t st_reg, st_next;

  assign frame_start = st_reg.fs;
  assign slot_tick = st_reg.sl;
  assign frame_odd = st_reg.par;

  // one frame per SPF samples, PPF evenly spaced slots inside it
  always_comb begin
    st_next = st_reg;
    st_next.fs = 1'b0;
    st_next.sl = 1'b0;
    if (!en) begin
      st_next.cnt = '0;
    end else if (sample_tick) begin
      if (st_reg.cnt == '0) begin
        st_next.fs = 1'b1; // R4
        st_next.par = st_reg.odd;
        st_next.odd = ~st_reg.odd;
      end
      if (st_reg.cnt[SW-1:0] == '0) begin
        st_next.sl = 1'b1; // R6
      end
      st_next.cnt = (st_reg.cnt == CW'(SPF - 1)) ? '0 : st_reg.cnt + 1'b1; // R5
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// *** rtl/aad_pkg.sv ***
// aad_pkg: types shared by the aux data channel files
// assumes aad_defs.svh for the numeric constants
package aad_pkg;

  // one classic wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } aad_wb_req_t;

  // five-byte return payload, byte 0 first on air
  typedef struct packed {
    logic [7:0] b4;
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } aad_ret_payload_t;

endpackage

// *** tb/aad_chk_sva.sv ***
// aad_chk_sva: port timing checks for the aux data channel
// assumes one clock domain; bound into aad_channel below
`timescale 1ns/10ps
module aad_chk_sva #(
  parameter int SPF = 128
) (
  input wire logic clk,
  input wire logic nrst,
  input aad_pkg::aad_wb_req_t wb_req,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0] general_inputs,
  input wire logic sample_tick,
  input wire logic fwd_valid,
  input wire logic ret_valid,
  input wire logic mst_valid,
  input wire logic mst_ready
);
  int tick_reg;
  int fwd_reg;
  logic seen_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ticks and forward bytes since the last return payload; seen skips the first frame
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_reg <= 0;
      fwd_reg <= 0;
      seen_reg <= 1'b0;
    end else begin
      tick_reg <= ret_valid ? int'(sample_tick) : tick_reg + int'(sample_tick);
      fwd_reg <= ret_valid ? int'(fwd_valid) : fwd_reg + int'(fwd_valid);
      seen_reg <= seen_reg | ret_valid;
    end
  end
  // forward-data writes may wait for room, so they are left out of the fast path
  sequence s_take;
    wb_req.cyc && wb_req.stb && !wb_ack_o && wb_req.adr != 12'h028;
  endsequence
  sequence s_gin_rd;
    wb_ack_o && !wb_req.we && wb_req.adr == 12'h01C;
  endsequence
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_next; s_take |=> wb_ack_o; endproperty
  property p_gin_val;
    s_gin_rd ##0 ($stable(general_inputs) && $past(general_inputs, 2) == general_inputs)
      |-> wb_dat_o[3:0] == general_inputs;
  endproperty
  property p_gin_resv; s_gin_rd |-> wb_dat_o[31:4] == 28'h000_0000; endproperty
  property p_ret_lat; ret_valid |-> $past(sample_tick, 2); endproperty
  property p_fwd_lat; fwd_valid |-> $past(sample_tick, 2); endproperty
  property p_frame; ret_valid && seen_reg |-> tick_reg == SPF; endproperty
  property p_fwd_frame; fwd_valid && !ret_valid |-> fwd_reg < 4; endproperty
  property p_mst_take; mst_valid && mst_ready |=> !mst_ready; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  a_gin_val: assert property (p_gin_val) else $error("input status wrong");
  a_gin_resv: assert property (p_gin_resv) else $error("reserved bits not zero");
  a_ret_lat: assert property (p_ret_lat) else $error("return payload off tick");
  a_fwd_lat: assert property (p_fwd_lat) else $error("forward byte off tick");
  a_frame: assert property (p_frame) else $error("frame length wrong");
  a_fwd_frame: assert property (p_fwd_frame) else $error("too many forward bytes");
  a_mst_take: assert property (p_mst_take) else $error("master not held");
endmodule

bind aad_channel aad_chk_sva #(.SPF(SPF)) chk_u (.clk(clk), .nrst(nrst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .general_inputs(general_inputs), .sample_tick(sample_tick), .fwd_valid(fwd_valid),
  .ret_valid(ret_valid), .mst_valid(mst_valid), .mst_ready(mst_ready));

// *** tb/aad_peer.sv ***
// aad_peer: far-side link logic making audio ticks and packet outcomes
// assumes the bench steers run and ok and reads the captured queues
`timescale 1ns/10ps
module aad_peer #(
  parameter int GAP = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic ok,
  input wire logic fwd_valid,
  input wire logic [7:0] fwd_data,
  input wire logic ret_valid,
  input aad_pkg::aad_ret_payload_t ret_payload,
  output logic sample_tick,
  output logic pkt_done,
  output logic pkt_ok
);
  int cnt = 0;
  int n_ok = 0;
  logic [7:0] fq[$];
  aad_pkg::aad_ret_payload_t rq[$];
  // defined levels before the first edge
  initial begin
    sample_tick = 1'b0;
    pkt_done = 1'b0;
    pkt_ok = 1'b0;
  end
  // one sample per GAP cycles; pkt_ok toggles between outcomes so it is never trusted idle
  always @(posedge clk) begin
    cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    sample_tick <= nrst && run && cnt == 0;
    pkt_done <= sample_tick;
    pkt_ok <= sample_tick ? ok : ~pkt_ok;
    n_ok <= n_ok + int'(pkt_done && pkt_ok);
    if (fwd_valid) fq.push_back(fwd_data);
    if (ret_valid) rq.push_back(ret_payload);
  end
endmodule

// *** tb/tb_aad_channel.sv ***
// tb_aad_channel: register, forward queue and return payload tests
// assumes aad_peer on the link side and a short frame via SPF
`timescale 1ns/10ps
module tb_aad_channel;
  localparam int SPF = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  aad_pkg::aad_wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, src_ready, fwd_valid, mst_ready, ret_valid, sample_tick, pkt_done, pkt_ok, found;
  logic [3:0] general_inputs = 4'h0;
  logic [7:0] src_data = 8'h00, mst_addr = 8'h00, fwd_data;
  logic [15:0] mst_data = 16'h0000;
  logic src_valid = 1'b0, mst_valid = 1'b0, run = 1'b0, ok = 1'b1;
  aad_pkg::aad_ret_payload_t ret_payload;
  logic [7:0] exp_q [8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h77, 8'h20, 8'h21, 8'h22};
  int n_mismatch = 0, n_tests = 0, i;

  always #25 clk = ~clk;

  aad_channel #(.FIFO_DEPTH(8), .SPF(SPF), .LQ_WINDOW(256)) dut_u (.clk(clk), .nrst(nrst), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .general_inputs(general_inputs), .parallel_port(8'h5A),
    .sample_tick(sample_tick), .pkt_done(pkt_done), .pkt_ok(pkt_ok), .src_valid(src_valid), .src_data(src_data),
    .src_ready(src_ready), .fwd_valid(fwd_valid), .fwd_data(fwd_data), .mst_valid(mst_valid),
    .mst_addr(mst_addr), .mst_data(mst_data), .mst_ready(mst_ready), .ret_valid(ret_valid),
    .ret_payload(ret_payload));
  aad_peer #(.GAP(4)) peer_u (.clk(clk), .nrst(nrst), .run(run), .ok(ok), .fwd_valid(fwd_valid),
    .fwd_data(fwd_data), .ret_valid(ret_valid), .ret_payload(ret_payload), .sample_tick(sample_tick),
    .pkt_done(pkt_done), .pkt_ok(pkt_ok));

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle: hold until ack is seen, then drop cyc for a cycle
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_req <= {1'b1, 1'b1, we, a, 4'h1, d};
    do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 200);
    if (n >= 200) chk(1'b0, 1'b1, "bus ack");
    q = wb_dat_o;
    wb_req <= '0;
    @(posedge clk);
  endtask

  // valid stays up so back-to-back pushes never assign it twice in one step
  task automatic push(input logic [7:0] b);
    int n;
    n = 0;
    src_valid <= 1'b1;
    src_data <= b;
    do begin @(posedge clk); n++; end while (src_ready !== 1'b1 && n < 200);
  endtask

  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // cut a hang well after the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report;
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wb(1'b0, 12'h01C, 32'h0000_0000); chk(q, 32'h0000_0000, "input reset");
    general_inputs <= 4'hA;
    repeat (2) @(posedge clk);
    wb(1'b0, 12'h01C, 32'h0000_0000); chk(q, 32'h0000_000A, "input level");
    wb(1'b1, 12'h01C, 32'h0000_00FF);
    wb(1'b0, 12'h01C, 32'h0000_0000); chk(q, 32'h0000_000A, "read-only");
    wb(1'b0, 12'h010, 32'h0000_0000); chk(q, 32'h0000_0000, "quality reset");
    wb(1'b0, 12'h400, 32'h0000_0000); chk(q, 32'h0000_0000, "unmapped");
    wb(1'b1, 12'h020, 32'h0000_0003);
    wb(1'b0, 12'h020, 32'h0000_0000); chk(q, 32'h0000_0003, "ctrl");
    $display("test registers done");
    for (i = 0; i < 4; i++) push(8'(8'h10 + i));
    src_valid <= 1'b0;
    @(posedge clk);
    wb(1'b1, 12'h028, 32'h0000_0077);
    for (i = 0; i < 3; i++) push(8'(8'h20 + i));
    src_valid <= 1'b0;
    @(negedge clk); chk(src_ready, 1'b0, "queue full");
    @(posedge clk);
    wb(1'b0, 12'h024, 32'h0000_0000); chk(q, 32'h0000_0800, "queue level");
    run <= 1'b1;
    i = 0;
    while (peer_u.fq.size() < 8 && i < 2000) begin @(posedge clk); i++; end
    for (i = 0; i < 8; i++) chk(peer_u.fq[i], exp_q[i], "forward order");
    $display("test forward done");
    mst_valid <= 1'b1;
    mst_addr <= 8'h3C;
    mst_data <= 16'hBEEF;
    ok <= 1'b0;
    @(posedge clk);
    mst_valid <= 1'b0;
    i = 0;
    do begin @(posedge clk); i++; end while (mst_ready !== 1'b1 && i < 2000);
    i = 0;
    do begin @(posedge clk); i++; end while (ret_valid !== 1'b1 && i < 200);
    @(posedge clk);
    found = 1'b0;
    for (i = 0; i + 1 < peer_u.rq.size(); i++) if (peer_u.rq[i].b2 === 8'hA5) begin
      found = 1'b1;
      chk({peer_u.rq[i].b3, peer_u.rq[i].b4, peer_u.rq[i + 1].b2}, 24'h3C_EFBE, "master split");
      chk(peer_u.rq[i].b1, 8'h5A, "port state");
      chk({peer_u.rq[i + 1].b3, peer_u.rq[i + 1].b4}, 16'h0000, "spare bytes");
    end
    chk(found, 1'b1, "master sent");
    run <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b0, 12'h010, 32'h0000_0000); chk(q, 32'(peer_u.n_ok), "quality count");
    $display("test return done");
    final_report;
  end
endmodule
